// >>> include/pfb_pkg.sv
`default_nettype none
package pfb_pkg;
	// ----------------------------------------
	// Graphics mode control fields
	// ----------------------------------------
	localparam int WRITE_MODE_LSB = 0;
	localparam int RESERVED_BIT   = 2;
	localparam int READ_MODE_BIT  = 3;
	localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
	localparam logic [7:0] MODE_CTRL_WMASK = 8'hFB;
	localparam logic [7:0] BYTE_RESET      = 8'h00;
	localparam logic [3:0] NIBBLE_RESET    = 4'h0;
	localparam logic [2:0] ROTATE_RESET    = 3'h0;
	localparam logic [1:0] PLANE_RESET     = 2'h0;

	typedef enum logic [1:0] {
		WM_DIRECT  = 2'b00,
		WM_LATCH   = 2'b01,
		WM_COLOR   = 2'b10,
		WM_SETMASK = 2'b11
	} pfb_wmode_e;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] p3;
		logic [7:0] p2;
		logic [7:0] p1;
		logic [7:0] p0;
	} pfb_planes_s;

	typedef struct packed {
		logic [3:0] setResetValue;
		logic [3:0] enableSetResetMask;
		logic [3:0] colorCompareValue;
		logic [2:0] dataRotateControl;
		logic [1:0] readPlaneSelector;
		logic [3:0] colorDontCareEnables;
		logic [7:0] pixelBitMask;
	} pfb_cfg_s;
endpackage
`default_nettype wire

// >>> rtl/pfb_datapath.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Mode bit 3 selects plain plane read at 0, colour-compare read at 1.
// - Plain read returns the byte of the plane named by the selector.
// - Compare read checks every bit of enabled planes against compare bits.
// - A don't-care bit of 0 keeps that plane from ever causing a mismatch.
// - A result bit is 1 only where every included plane matches its bit.
// - Mode control bit 2 always reads back as zero.
// - Write mode 0 writes the rotated CPU byte into planes with enable set/reset 0.
// - Write mode 0 puts the set/reset bit in planes with enable set/reset 1.
// - Write mode 1 writes the four read latches back, ignoring CPU data.
// - Each read copies raw plane data to the latches, kept till next read.
// - Write mode 2 takes CPU data bits 3..0 as one colour bit per plane.
// - In write mode 2 a bit mask 0 position is written from the latches.
// - In write mode 2 a mask 1 position gets the plane's colour bit.
// - Write mode 3 masks set/reset values with CPU data AND the bit mask.
module pfb_datapath (
	// Clock, reset, enable
	input  wire logic                clk,
	input  wire logic                sys_rst,
	input  wire logic                clkEn,
	// Mode control register port
	input  wire logic                modeWrEn,
	input  wire logic [7:0]          modeWrData,
	output logic      [7:0]          modeRdData,
	// Other graphics settings
	input  wire pfb_pkg::pfb_cfg_s   cfg,
	// CPU side
	input  wire logic                cpuRd,
	input  wire logic                cpuWr,
	input  wire logic [7:0]          cpuWrData,
	output logic      [7:0]          cpuRdData,
	output logic                     cpuRdValid,
	// Plane side
	input  wire pfb_pkg::pfb_planes_s planeRdData,
	output pfb_pkg::pfb_planes_s     planeWrData,
	output logic                     planeWrEn
);
	// ----------------------------------------
	// Mode control register
	// ----------------------------------------
	logic [7:0] modeCtrl_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			modeCtrl_q <= pfb_pkg::MODE_CTRL_RESET;
		end else if (clkEn && modeWrEn) begin
			modeCtrl_q <= modeWrData & pfb_pkg::MODE_CTRL_WMASK;
		end
	end
	assign modeRdData = modeCtrl_q;

	logic readCompare;
	pfb_pkg::pfb_wmode_e wMode;
	assign readCompare = modeCtrl_q[pfb_pkg::READ_MODE_BIT];
	assign wMode = pfb_pkg::pfb_wmode_e'(
		modeCtrl_q[pfb_pkg::WRITE_MODE_LSB +: 2]);

	// ----------------------------------------
	// Read path and latches
	// ----------------------------------------
	logic [3:0][7:0] rdPlanes;
	logic [3:0][7:0] latch_q;
	logic [7:0]      cmpResult;
	logic [7:0]      plainResult;
	assign rdPlanes = planeRdData;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			latch_q <= '0;
		end else if (clkEn && cpuRd) begin
			latch_q <= rdPlanes;
		end
	end

	assign plainResult = rdPlanes[cfg.readPlaneSelector];

	genvar b;
	generate
		for (b = 0; b < 8; b++) begin : gCmp
			logic [3:0] miss;
			for (genvar p = 0; p < 4; p++) begin : gPl
				assign miss[p] = cfg.colorDontCareEnables[p] &&
					(rdPlanes[p][b] != cfg.colorCompareValue[p]);
			end
			assign cmpResult[b] = ~|miss;
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cpuRdData  <= pfb_pkg::BYTE_RESET;
			cpuRdValid <= 1'b0;
		end else if (clkEn) begin
			cpuRdValid <= cpuRd;
			if (cpuRd) begin
				cpuRdData <= readCompare ? cmpResult : plainResult;
			end
		end
	end

	// ----------------------------------------
	// Write path
	// ----------------------------------------
	logic [7:0]      rotated;
	logic [7:0]      m3Mask;
	logic [3:0][7:0] wrNext;
	logic [15:0]     dbl;
	assign dbl     = {cpuWrData, cpuWrData};
	assign rotated = dbl[cfg.dataRotateControl +: 8];
	assign m3Mask  = cpuWrData & cfg.pixelBitMask;

	generate
		for (genvar p = 0; p < 4; p++) begin : gWr
			logic [7:0] srByte;
			logic [7:0] colByte;
			logic [7:0] wrByte;
			assign srByte  = {8{cfg.setResetValue[p]}};
			assign colByte = {8{cpuWrData[p]}};
			always_comb begin
				case (wMode)
					pfb_pkg::WM_DIRECT:
						wrByte = cfg.enableSetResetMask[p] ?
							srByte : rotated;
					pfb_pkg::WM_LATCH:
						wrByte = latch_q[p];
					pfb_pkg::WM_COLOR:
						wrByte = (colByte & cfg.pixelBitMask) |
							(latch_q[p] & ~cfg.pixelBitMask);
					pfb_pkg::WM_SETMASK:
						wrByte = (srByte & m3Mask) |
							(latch_q[p] & ~m3Mask);
					default:
						wrByte = latch_q[p];
				endcase
			end
			// One continuous driver per plane slice
			assign wrNext[p] = wrByte;
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			planeWrData <= '0;
			planeWrEn   <= 1'b0;
		end else if (clkEn) begin
			planeWrEn <= cpuWr;
			if (cpuWr) begin
				planeWrData <= wrNext;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
		modeRdData[pfb_pkg::RESERVED_BIT] == 1'b0)
		else $error("reserved mode bit reads nonzero");
	a_plain_read: assert property (@(posedge clk) disable iff (sys_rst)
		(clkEn && cpuRd && !readCompare) |=> cpuRdData == $past(plainResult))
		else $error("plain read data wrong");
	a_compare_read: assert property (@(posedge clk) disable iff (sys_rst)
		(clkEn && cpuRd && readCompare) |=> cpuRdData == $past(cmpResult))
		else $error("compare read data wrong");
	a_dontcare_all: assert property (@(posedge clk) disable iff (sys_rst)
		(clkEn && cpuRd && readCompare && cfg.colorDontCareEnables == 4'h0)
		|=> cpuRdData == 8'hFF)
		else $error("no plane included yet mismatch");
	a_latch_load: assert property (@(posedge clk) disable iff (sys_rst)
		(clkEn && cpuRd) |=> latch_q == $past(rdPlanes))
		else $error("latches not loaded on read");
	a_latch_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!cpuRd |=> $stable(latch_q))
		else $error("latches changed without read");
	a_mode1_latch: assert property (@(posedge clk) disable iff (sys_rst)
		(clkEn && cpuWr && wMode == pfb_pkg::WM_LATCH)
		|=> planeWrData == $past(latch_q) && planeWrEn)
		else $error("mode 1 did not write latches");
	a_mode0_plain: assert property (@(posedge clk) disable iff (sys_rst)
		(clkEn && cpuWr && wMode == pfb_pkg::WM_DIRECT &&
		cfg.enableSetResetMask == 4'h0 && cfg.dataRotateControl == 3'h0)
		|=> planeWrData == {4{$past(cpuWrData)}})
		else $error("mode 0 data wrong");
	a_mode2_full: assert property (@(posedge clk) disable iff (sys_rst)
		(clkEn && cpuWr && wMode == pfb_pkg::WM_COLOR &&
		cfg.pixelBitMask == 8'hFF)
		|=> planeWrData.p0 == {8{$past(cpuWrData[0])}})
		else $error("mode 2 colour wrong");
	a_mode3_nomask: assert property (@(posedge clk) disable iff (sys_rst)
		(clkEn && cpuWr && wMode == pfb_pkg::WM_SETMASK &&
		(cpuWrData & cfg.pixelBitMask) == 8'h00)
		|=> planeWrData == $past(latch_q))
		else $error("mode 3 masked bits not from latches");
	a_latch_freeze: assert property (@(posedge clk) disable iff (sys_rst)
		!clkEn |=> $stable(latch_q) && $stable(modeCtrl_q))
		else $error("state moved while clock enable low");
	a_rdvalid_pulse: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn |=> cpuRdValid == $past(cpuRd))
		else $error("read valid not one cycle after read");
	a_wren_pulse: assert property (@(posedge clk) disable iff (sys_rst)
		clkEn |=> planeWrEn == $past(cpuWr))
		else $error("plane write enable not one cycle after write");
	a_plane0_read: assert property (@(posedge clk) disable iff (sys_rst)
		(clkEn && cpuRd && !readCompare && cfg.readPlaneSelector == 2'h0)
		|=> cpuRdData == $past(planeRdData.p0))
		else $error("plane 0 read data wrong");
	a_mode0_rotate: assert property (@(posedge clk) disable iff (sys_rst)
		(clkEn && cpuWr && wMode == pfb_pkg::WM_DIRECT &&
		!cfg.enableSetResetMask[1] && cfg.dataRotateControl == 3'h1)
		|=> planeWrData.p1 == {$past(cpuWrData[0]), $past(cpuWrData[7:1])})
		else $error("mode 0 rotate by one wrong");
	a_mode0_setreset: assert property (@(posedge clk) disable iff (sys_rst)
		(clkEn && cpuWr && wMode == pfb_pkg::WM_DIRECT &&
		cfg.enableSetResetMask[0])
		|=> planeWrData.p0 == {8{$past(cfg.setResetValue[0])}})
		else $error("mode 0 set/reset value wrong");
	a_mode2_nomask: assert property (@(posedge clk) disable iff (sys_rst)
		(clkEn && cpuWr && wMode == pfb_pkg::WM_COLOR &&
		cfg.pixelBitMask == 8'h00)
		|=> planeWrData == $past(latch_q))
		else $error("mode 2 masked bits not from latches");
	a_mode3_full: assert property (@(posedge clk) disable iff (sys_rst)
		(clkEn && cpuWr && wMode == pfb_pkg::WM_SETMASK &&
		(cpuWrData & cfg.pixelBitMask) == 8'hFF)
		|=> planeWrData.p1 == {8{$past(cfg.setResetValue[1])}})
		else $error("mode 3 set/reset value wrong");
endmodule
`default_nettype wire

// >>> tb/pfb_plane_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfb_plane_model (
	// Clock
	input  wire logic                 clk,
	// Plane side
	input  wire pfb_pkg::pfb_planes_s wrData,
	input  wire logic                 wrEn,
	output pfb_pkg::pfb_planes_s      rdData
);
	pfb_pkg::pfb_planes_s mem_q = '0;

	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem_q <= wrData;
		end
	end

	assign rdData = mem_q;
endmodule
`default_nettype wire

// >>> tb/pfb_datapath_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pfb_datapath_tb;
	localparam logic [31:0] PLANES = 32'hD200D2FF;
	logic                 clk;
	logic                 sysRst;
	logic                 clkEn;
	logic                 modeWrEn;
	logic                 cpuRd;
	logic                 cpuWr;
	logic                 cpuRdValid;
	logic                 planeWrEn;
	logic [7:0]           modeWrData;
	logic [7:0]           modeRdData;
	logic [7:0]           cpuWrData;
	logic [7:0]           cpuRdData;
	pfb_pkg::pfb_cfg_s    cfg;
	pfb_pkg::pfb_planes_s planeRdData;
	pfb_pkg::pfb_planes_s planeWrData;
	int                   errTotal;
	int                   numChecks;

	pfb_datapath dut (.clk(clk), .sys_rst(sysRst), .clkEn(clkEn),
		.modeWrEn(modeWrEn), .modeWrData(modeWrData),
		.modeRdData(modeRdData), .cfg(cfg), .cpuRd(cpuRd), .cpuWr(cpuWr),
		.cpuWrData(cpuWrData), .cpuRdData(cpuRdData),
		.cpuRdValid(cpuRdValid), .planeRdData(planeRdData),
		.planeWrData(planeWrData), .planeWrEn(planeWrEn));
	pfb_plane_model planes (.clk(clk), .wrData(planeWrData),
		.wrEn(planeWrEn), .rdData(planeRdData));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			errTotal++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic setMode(input logic [7:0] d);
		@(posedge clk);
		modeWrEn   <= 1'b1;
		modeWrData <= d;
		@(posedge clk);
		modeWrEn <= 1'b0;
		#1;
	endtask

	task automatic setCfg(input logic [3:0] sr, esr, cc, input logic [2:0] rot,
		input logic [1:0] sel, input logic [3:0] dc, input logic [7:0] bm);
		@(posedge clk);
		cfg <= {sr, esr, cc, rot, sel, dc, bm};
	endtask

	task automatic rdChk(input logic [7:0] e);
		@(posedge clk);
		cpuRd <= 1'b1;
		@(posedge clk);
		cpuRd <= 1'b0;
		#1;
		chk({31'h0, cpuRdValid}, 32'h1);
		chk({24'h0, cpuRdData}, {24'h0, e});
	endtask

	task automatic wrChk(input logic [7:0] d, input logic [31:0] e);
		@(posedge clk);
		cpuWr     <= 1'b1;
		cpuWrData <= d;
		@(posedge clk);
		cpuWr <= 1'b0;
		#1;
		chk({31'h0, planeWrEn}, 32'h1);
		chk(planeWrData, e);
	endtask

	task automatic endSim;
		$display("checks %0d errors %0d", numChecks, errTotal);
		if (errTotal == 0 && numChecks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		sysRst     = 1'b1;
		clkEn      = 1'b1;
		modeWrEn   = 1'b0;
		modeWrData = 8'h00;
		cpuRd      = 1'b0;
		cpuWr      = 1'b0;
		cpuWrData  = 8'h00;
		cfg        = '0;
		errTotal   = 0;
		numChecks  = 0;
		repeat (4) @(posedge clk);
		sysRst <= 1'b0;
		#1;
		chk({24'h0, modeRdData}, 32'h0);
		setMode(8'hFF);
		chk({24'h0, modeRdData}, 32'hFB);
		setMode(8'h00);
		setCfg(4'h0, 4'h0, 4'h0, 3'h0, 2'h0, 4'h0, 8'hFF);
		wrChk(8'hA5, 32'hA5A5A5A5);
		setCfg(4'h1, 4'h5, 4'h0, 3'h1, 2'h0, 4'h0, 8'hFF);
		wrChk(8'hA5, PLANES);
		for (int i = 0; i < 4; i++) begin
			setCfg(4'h1, 4'h5, 4'h0, 3'h1, 2'(i), 4'h0, 8'hFF);
			rdChk(PLANES[i*8 +: 8]);
		end
		setMode(8'h08);
		setCfg(4'h0, 4'h0, 4'hA, 3'h0, 2'h0, 4'hE, 8'hFF);
		rdChk(8'hD2);
		setCfg(4'h0, 4'h0, 4'hA, 3'h0, 2'h0, 4'h0, 8'hFF);
		rdChk(8'hFF);
		setCfg(4'h0, 4'h0, 4'hA, 3'h0, 2'h0, 4'hF, 8'hFF);
		rdChk(8'h00);
		setMode(8'h01);
		wrChk(8'h00, PLANES);
		setMode(8'h02);
		setCfg(4'hA, 4'h0, 4'h0, 3'h0, 2'h0, 4'h0, 8'h0F);
		wrChk(8'hF5, 32'hD00FD0FF);
		setMode(8'h03);
		wrChk(8'h3C, 32'hDE00DEF3);
		wrChk(8'hC0, PLANES);
		setCfg(4'hA, 4'h0, 4'h0, 3'h0, 2'h0, 4'h0, 8'hFF);
		wrChk(8'hFF, 32'hFF00FF00);
		setMode(8'h02);
		wrChk(8'h05, 32'h00FF00FF);
		setCfg(4'hA, 4'h0, 4'h0, 3'h0, 2'h0, 4'h0, 8'h00);
		wrChk(8'h0F, PLANES);
		// Clock enable low freezes every request
		@(posedge clk);
		clkEn      <= 1'b0;
		cpuRd      <= 1'b1;
		cpuWr      <= 1'b1;
		modeWrEn   <= 1'b1;
		modeWrData <= 8'h00;
		@(posedge clk);
		clkEn    <= 1'b1;
		cpuRd    <= 1'b0;
		cpuWr    <= 1'b0;
		modeWrEn <= 1'b0;
		#1;
		chk({31'h0, cpuRdValid}, 32'h0);
		chk({31'h0, planeWrEn}, 32'h0);
		chk({24'h0, modeRdData}, 32'h02);
		// Reset in mid-run clears mode, outputs and latches
		@(posedge clk);
		sysRst <= 1'b1;
		repeat (2) @(posedge clk);
		sysRst <= 1'b0;
		#1;
		chk({24'h0, modeRdData}, 32'h0);
		chk(planeWrData, 32'h0);
		setMode(8'h01);
		wrChk(8'hFF, 32'h0);
		endSim();
	end
endmodule
`default_nettype wire
